// [rtl/dpsc_params.svh]
// Constants for the display power and status command block
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH
`define DPSC_OP_SIGNAL_MODE_READ 8'h0E
`define DPSC_OP_SELF_DIAG_READ 8'h0F
`define DPSC_OP_SLEEP_ENTER 8'h10
`define DPSC_OP_SLEEP_EXIT 8'h11
`define DPSC_OP_PARTIAL_ON 8'h12
`define DPSC_OP_NORMAL_ON 8'h13
`define DPSC_OP_INVERSION_OFF 8'h20
`define DPSC_OP_POWER_MODE_READ 8'h0A
`define DPSC_SIGNAL_MODE_RESET 8'h00
`define DPSC_SELF_DIAG_RESET 8'h00
`define DPSC_BIT_TE_ON 7
`define DPSC_BIT_TE_MODE 6
`define DPSC_BIT_HSYNC 5
`define DPSC_BIT_VSYNC 4
`define DPSC_BIT_PCLK 3
`define DPSC_BIT_DE 2
`define DPSC_BIT_REG_LOAD 7
`define DPSC_BIT_FUNC 6
`define DPSC_PM_IDLE 6
`define DPSC_PM_PARTIAL 5
`define DPSC_PM_SLEEP_OUT 4
`define DPSC_PM_NORMAL 3
`define DPSC_PM_DISPLAY_ON 2
`define DPSC_DIAG_CYCLES 16'h0010
`endif

// [rtl/dpsc_pkg.sv]
// Types for the display power and status command block
package dpsc_pkg;
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic pclk;
    logic pixel_valid;
  } dpsc_sync_type;
  typedef struct packed {
    logic osc_en;
    logic bias_en;
    logic anode_to_ground;
    logic cathode_to_ground;
    logic scan_en;
  } dpsc_power_type;
  typedef enum logic [1:0] {
    DPSC_AWAKE,
    DPSC_ASLEEP,
    DPSC_DIAG
  } dpsc_state_type;
endpackage : dpsc_pkg

// [rtl/dpsc_diag.sv]
// Self-diagnostic sequencer run after leaving sleep
`timescale 1ns/1ps
`include "dpsc_params.svh"
module dpsc_diag
  import dpsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic reg_load_ok_in,
  input wire logic func_ok_in,
  output logic busy_out,
  output logic [7:0] result_out
);
  logic [15:0] count;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count <= 16'h0000;
      busy_out <= 1'b0;
    end
    else if (start_in)
    begin
      count <= `DPSC_DIAG_CYCLES;
      busy_out <= 1'b1;
    end
    else if (busy_out)
    begin
      count <= count - 16'h0001;
      if (count == 16'h0001)
        busy_out <= 1'b0;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      result_out <= `DPSC_SELF_DIAG_RESET;
    else if (busy_out && count == 16'h0001)
    begin
      result_out <= 8'h00;
      result_out[`DPSC_BIT_REG_LOAD] <= reg_load_ok_in;
      result_out[`DPSC_BIT_FUNC] <= func_ok_in;
    end
  end
endmodule : dpsc_diag

// [rtl/dpsc_invert.sv]
// Holds inversion state and applies changes at the transfer phase
`timescale 1ns/1ps
module dpsc_invert
  import dpsc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic off_req_in,
  input wire logic on_req_in,
  input wire logic transfer_start_in,
  output logic invert_out,
  output logic pending_out
);
  logic target;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      target <= 1'b0;
    else if (off_req_in)
      target <= 1'b0;
    else if (on_req_in)
      target <= 1'b1;
  end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      invert_out <= 1'b0;
    else if (transfer_start_in)
      invert_out <= target;
  end
  assign pending_out = target != invert_out;
endmodule : dpsc_invert

// [rtl/dpsc_top.sv]
// Display power and status command decoder
// Function
// - Signal-mode read returns tearing, sync, clock, enable bits; bits 1..0 zero.
// - Tearing mode bit: 0 vertical blanking only, 1 both blankings.
// - RGB mode with control bit0 clear captures pins, else internal signals.
// - Self-diagnostic read: bit7 register load, bit6 function, rest zero.
// - Sleep-enter disables all but host interface, keeps frame memory.
// - Sleep grounds anodes and cathodes, stops oscillator and bias generators.
// - In sleep commands work; memory only with manually started oscillator.
// - Sleep-enter does nothing when already asleep.
// - Sleep-exit enables generators, oscillator and scanning; shows memory if on.
// - Leaving sleep reloads register defaults.
// - Sleep-exit runs self-diagnostics and updates result bits.
// - Sleep-exit has no visible effect when not asleep.
// - Partial-on enables partial mode; no effect if already partial.
// - Normal-on disables partial mode; no effect if already normal.
// - Inversion-off stops inversion only; no effect when not inverting.
// - Inversion change applies at next refresh transfer phase.
// - Power-mode read reports idle, partial, sleep-out, normal, display-on.
`timescale 1ns/1ps
`include "dpsc_params.svh"
module dpsc_top
  import dpsc_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic SOFT_RESET_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [7:0] CMD_IN,
  output logic READ_VALID_OUT,
  output logic [7:0] READ_DATA_OUT,
  output logic CMD_HIT_OUT,
  input wire logic RGB_MODE_IN,
  input wire logic DISPLAY_CONTROL_BIT0_IN,
  input wire logic HORIZONTAL_SYNC_PIN_IN,
  input wire logic VERTICAL_SYNC_PIN_IN,
  input wire logic PIXEL_CLOCK_PIN_IN,
  input wire logic PIXEL_VALID_PIN_IN,
  input wire logic INT_HSYNC_IN,
  input wire logic INT_VSYNC_IN,
  input wire logic INT_PCLK_IN,
  input wire logic INT_PIXEL_VALID_IN,
  input wire logic TEAR_ENABLE_IN,
  input wire logic TEAR_BOTH_BLANKING_IN,
  input wire logic IDLE_MODE_IN,
  input wire logic DISPLAY_ON_IN,
  input wire logic INVERSION_ON_REQ_IN,
  input wire logic TRANSFER_PHASE_START_IN,
  input wire logic MANUAL_OSC_START_IN,
  input wire logic REG_LOAD_OK_IN,
  input wire logic FUNC_OK_IN,
  output logic OSC_EN_OUT,
  output logic BIAS_EN_OUT,
  output logic ANODE_TO_GROUND_OUT,
  output logic CATHODE_TO_GROUND_OUT,
  output logic SCAN_EN_OUT,
  output logic SHOW_MEMORY_OUT,
  output logic FRAME_MEMORY_ACCESS_OUT,
  output logic RELOAD_DEFAULTS_OUT,
  output logic PARTIAL_MODE_OUT,
  output logic INVERT_OUT,
  output logic INVERT_PENDING_OUT
);
  logic rst_meta;
  logic rst_n;
  dpsc_state_type state;
  dpsc_power_type power;
  dpsc_sync_type sync_now;
  logic partial;
  logic diag_busy;
  logic diag_start;
  logic [7:0] diag_result;
  logic [7:0] signal_mode;
  logic inversion;
  logic inversion_off_req;
  logic sleeping;
  logic [7:0] power_mode;
  logic op_signal_read;
  logic op_diag_read;
  logic op_power_read;
  logic op_sleep_enter;
  logic op_sleep_exit;
  logic op_partial_on;
  logic op_normal_on;
  logic op_inversion_off;
  logic op_read;

  function automatic logic is_cmd(input logic valid, input logic [7:0] code, input logic [7:0] op);
    is_cmd = valid && code == op;
  endfunction : is_cmd

  // One strobe per handled command
  always_comb
  begin
    op_signal_read = is_cmd(CMD_VALID_IN, CMD_IN, `DPSC_OP_SIGNAL_MODE_READ);
    op_diag_read = is_cmd(CMD_VALID_IN, CMD_IN, `DPSC_OP_SELF_DIAG_READ);
    op_power_read = is_cmd(CMD_VALID_IN, CMD_IN, `DPSC_OP_POWER_MODE_READ);
    op_sleep_enter = is_cmd(CMD_VALID_IN, CMD_IN, `DPSC_OP_SLEEP_ENTER);
    op_sleep_exit = is_cmd(CMD_VALID_IN, CMD_IN, `DPSC_OP_SLEEP_EXIT);
    op_partial_on = is_cmd(CMD_VALID_IN, CMD_IN, `DPSC_OP_PARTIAL_ON);
    op_normal_on = is_cmd(CMD_VALID_IN, CMD_IN, `DPSC_OP_NORMAL_ON);
    op_inversion_off = is_cmd(CMD_VALID_IN, CMD_IN, `DPSC_OP_INVERSION_OFF);
    op_read = op_signal_read || op_diag_read || op_power_read;
  end

  // Reset release through two flops
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign sleeping = state == DPSC_ASLEEP;

  // Sleep state machine
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      state <= DPSC_ASLEEP;
    else if (SOFT_RESET_IN)
      state <= DPSC_ASLEEP;
    else
    begin
      case (state)
        DPSC_ASLEEP:
        begin
          if (op_sleep_exit)
            state <= DPSC_DIAG;
        end
        DPSC_AWAKE:
        begin
          if (op_sleep_enter)
            state <= DPSC_ASLEEP;
        end
        DPSC_DIAG:
        begin
          if (op_sleep_enter)
            state <= DPSC_ASLEEP;
          else if (!diag_busy && !diag_start)
            state <= DPSC_AWAKE;
        end
        default:
          state <= DPSC_ASLEEP;
      endcase
    end
  end

  // Self-diagnostics start only when truly leaving sleep
  assign diag_start = sleeping && op_sleep_exit;

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      RELOAD_DEFAULTS_OUT <= 1'b0;
    else
      RELOAD_DEFAULTS_OUT <= diag_start;
  end

  // Power control from sleep state
  always_comb
  begin
    power.osc_en = !sleeping;
    power.bias_en = !sleeping;
    power.anode_to_ground = sleeping;
    power.cathode_to_ground = sleeping;
    power.scan_en = !sleeping;
  end

  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      OSC_EN_OUT <= 1'b0;
      BIAS_EN_OUT <= 1'b0;
      SCAN_EN_OUT <= 1'b0;
    end
    else
    begin
      OSC_EN_OUT <= power.osc_en || MANUAL_OSC_START_IN;
      BIAS_EN_OUT <= power.bias_en;
      SCAN_EN_OUT <= power.scan_en;
    end
  end

  // Panel lines tied to their grounds while asleep
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ANODE_TO_GROUND_OUT <= 1'b1;
      CATHODE_TO_GROUND_OUT <= 1'b1;
    end
    else
    begin
      ANODE_TO_GROUND_OUT <= power.anode_to_ground;
      CATHODE_TO_GROUND_OUT <= power.cathode_to_ground;
    end
  end

  // Memory display and host access
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SHOW_MEMORY_OUT <= 1'b0;
      FRAME_MEMORY_ACCESS_OUT <= 1'b0;
    end
    else
    begin
      SHOW_MEMORY_OUT <= power.scan_en && DISPLAY_ON_IN;
      FRAME_MEMORY_ACCESS_OUT <= !sleeping || MANUAL_OSC_START_IN;
    end
  end

  // Partial versus normal display mode
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      partial <= 1'b0;
    else if (SOFT_RESET_IN)
      partial <= 1'b0;
    else if (op_partial_on)
      partial <= 1'b1;
    else if (op_normal_on)
      partial <= 1'b0;
  end
  assign PARTIAL_MODE_OUT = partial;

  assign inversion_off_req = op_inversion_off || SOFT_RESET_IN;

  // Inversion target, applied at the transfer phase
  dpsc_invert u_invert (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .off_req_in(inversion_off_req),
    .on_req_in(INVERSION_ON_REQ_IN),
    .transfer_start_in(TRANSFER_PHASE_START_IN),
    .invert_out(inversion),
    .pending_out(INVERT_PENDING_OUT)
  );
  assign INVERT_OUT = inversion;

  // Self-diagnostics after leaving sleep
  dpsc_diag u_diag (
    .clk_in(CLK_IN),
    .rst_n_in(rst_n),
    .start_in(diag_start),
    .reg_load_ok_in(REG_LOAD_OK_IN),
    .func_ok_in(FUNC_OK_IN),
    .busy_out(diag_busy),
    .result_out(diag_result)
  );

  // Sync source select
  always_comb
  begin
    if (RGB_MODE_IN && !DISPLAY_CONTROL_BIT0_IN)
    begin
      sync_now.hsync = HORIZONTAL_SYNC_PIN_IN;
      sync_now.vsync = VERTICAL_SYNC_PIN_IN;
      sync_now.pclk = PIXEL_CLOCK_PIN_IN;
      sync_now.pixel_valid = PIXEL_VALID_PIN_IN;
    end
    else
    begin
      sync_now.hsync = INT_HSYNC_IN;
      sync_now.vsync = INT_VSYNC_IN;
      sync_now.pclk = INT_PCLK_IN;
      sync_now.pixel_valid = INT_PIXEL_VALID_IN;
    end
  end

  // Signal-mode byte
  always_comb
  begin
    signal_mode = 8'h00;
    signal_mode[`DPSC_BIT_TE_ON] = TEAR_ENABLE_IN;
    signal_mode[`DPSC_BIT_TE_MODE] = TEAR_BOTH_BLANKING_IN;
    signal_mode[`DPSC_BIT_HSYNC] = sync_now.hsync;
    signal_mode[`DPSC_BIT_VSYNC] = sync_now.vsync;
    signal_mode[`DPSC_BIT_PCLK] = sync_now.pclk;
    signal_mode[`DPSC_BIT_DE] = sync_now.pixel_valid;
  end

  // Power-mode byte
  always_comb
  begin
    power_mode = 8'h00;
    power_mode[`DPSC_PM_IDLE] = IDLE_MODE_IN;
    power_mode[`DPSC_PM_PARTIAL] = partial;
    power_mode[`DPSC_PM_SLEEP_OUT] = !sleeping;
    power_mode[`DPSC_PM_NORMAL] = !partial;
    power_mode[`DPSC_PM_DISPLAY_ON] = DISPLAY_ON_IN;
  end

  // Status reads answer one cycle after the command
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      READ_VALID_OUT <= 1'b0;
    else
      READ_VALID_OUT <= op_read;
  end

  // Read byte holds until the next read
  always_ff @(posedge CLK_IN or negedge rst_n)
  begin
    if (!rst_n)
      READ_DATA_OUT <= 8'h00;
    else if (op_signal_read)
      READ_DATA_OUT <= signal_mode;
    else if (op_diag_read)
      READ_DATA_OUT <= diag_result & 8'hC0;
    else if (op_power_read)
      READ_DATA_OUT <= power_mode;
  end

  // Command recognised; decoding works in every state
  always_comb
  begin
    CMD_HIT_OUT = 1'b0;
    if (CMD_VALID_IN)
    begin
      case (CMD_IN)
        `DPSC_OP_SIGNAL_MODE_READ,
        `DPSC_OP_SELF_DIAG_READ,
        `DPSC_OP_POWER_MODE_READ,
        `DPSC_OP_SLEEP_ENTER,
        `DPSC_OP_SLEEP_EXIT,
        `DPSC_OP_PARTIAL_ON,
        `DPSC_OP_NORMAL_ON,
        `DPSC_OP_INVERSION_OFF:
          CMD_HIT_OUT = 1'b1;
        default:
          CMD_HIT_OUT = 1'b0;
      endcase
    end
  end
endmodule : dpsc_top

// [testbench/dpsc_top_asserts.sv]
// Assertion checker for the display power and status command block
`timescale 1ns/1ps
module dpsc_top_asserts (
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  input wire logic SOFT_RESET_IN,
  input wire logic CMD_VALID_IN,
  input wire logic [7:0] CMD_IN,
  input wire logic READ_VALID_OUT,
  input wire logic [7:0] READ_DATA_OUT,
  input wire logic TEAR_ENABLE_IN,
  input wire logic TEAR_BOTH_BLANKING_IN,
  input wire logic TRANSFER_PHASE_START_IN,
  input wire logic ANODE_TO_GROUND_OUT,
  input wire logic CATHODE_TO_GROUND_OUT,
  input wire logic BIAS_EN_OUT,
  input wire logic SCAN_EN_OUT,
  input wire logic RELOAD_DEFAULTS_OUT,
  input wire logic PARTIAL_MODE_OUT,
  input wire logic INVERT_OUT
);
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);
  chk_read_answer: assert property (CMD_VALID_IN && CMD_IN == 8'h0E |=> READ_VALID_OUT)
    else $error("read answer missing");
  chk_sig_fields: assert property ($past(CMD_VALID_IN && CMD_IN == 8'h0E) |-> READ_DATA_OUT[1:0] == 2'h0 &&
    READ_DATA_OUT[7] == $past(TEAR_ENABLE_IN) && READ_DATA_OUT[6] == $past(TEAR_BOTH_BLANKING_IN))
    else $error("signal mode byte wrong");
  chk_diag_zeros: assert property ($past(CMD_VALID_IN && CMD_IN == 8'h0F) |-> READ_DATA_OUT[5:0] == 6'h00)
    else $error("diagnostic low bits set");
  chk_sleep_ground: assert property (ANODE_TO_GROUND_OUT |-> CATHODE_TO_GROUND_OUT && !BIAS_EN_OUT && !SCAN_EN_OUT)
    else $error("sleep outputs inconsistent");
  chk_sleep_enter: assert property (CMD_VALID_IN && CMD_IN == 8'h10 && !SOFT_RESET_IN |-> ##2 ANODE_TO_GROUND_OUT)
    else $error("sleep not entered");
  chk_exit_wake: assert property (CMD_VALID_IN && CMD_IN == 8'h11 && ANODE_TO_GROUND_OUT && !SOFT_RESET_IN &&
    !$past(CMD_VALID_IN) |=> RELOAD_DEFAULTS_OUT ##1 (BIAS_EN_OUT && SCAN_EN_OUT && !ANODE_TO_GROUND_OUT))
    else $error("sleep exit incomplete");
  chk_reload_cause: assert property (RELOAD_DEFAULTS_OUT |-> $past(CMD_VALID_IN && CMD_IN == 8'h11))
    else $error("reload without exit");
  chk_partial_on: assert property (CMD_VALID_IN && CMD_IN == 8'h12 && !SOFT_RESET_IN |=> PARTIAL_MODE_OUT)
    else $error("partial not set");
  chk_normal_on: assert property (CMD_VALID_IN && CMD_IN == 8'h13 |=> !PARTIAL_MODE_OUT)
    else $error("partial not cleared");
  chk_invert_edge: assert property ($changed(INVERT_OUT) |-> $past(TRANSFER_PHASE_START_IN || SOFT_RESET_IN))
    else $error("inversion changed off phase");
  cover property (RELOAD_DEFAULTS_OUT);
  cover property (CMD_VALID_IN && CMD_IN == 8'h12);
  cover property ($fell(INVERT_OUT));
endmodule : dpsc_top_asserts

bind dpsc_top dpsc_top_asserts dpsc_top_asserts_inst (.CLK_IN, .ARST_N_IN, .SOFT_RESET_IN, .CMD_VALID_IN, .CMD_IN,
  .READ_VALID_OUT, .READ_DATA_OUT, .TEAR_ENABLE_IN, .TEAR_BOTH_BLANKING_IN, .TRANSFER_PHASE_START_IN,
  .ANODE_TO_GROUND_OUT, .CATHODE_TO_GROUND_OUT, .BIAS_EN_OUT, .SCAN_EN_OUT, .RELOAD_DEFAULTS_OUT,
  .PARTIAL_MODE_OUT, .INVERT_OUT);

// [testbench/dpsc_host_model.sv]
// Host processor model issuing single-byte commands
`timescale 1ns/1ps
module dpsc_host_model #(
  parameter int WAIT_CYCLES = 24
) (
  input wire logic clk_in,
  input wire logic hit_in,
  output logic cmd_valid_out,
  output logic [7:0] cmd_out
);
  logic hit = 1'h0;
  initial
  begin
    cmd_valid_out = 1'h0;
    cmd_out = 8'hA5;
  end
  task automatic send(input logic [7:0] code);
    @(negedge clk_in);
    cmd_valid_out = 1'h1;
    cmd_out = code;
    @(posedge clk_in);
    hit = hit_in;
    @(negedge clk_in);
    cmd_valid_out = 1'h0;
    cmd_out = ~code;
    // Settling wait after sleep changes, scaled down
    if (code == 8'h10 || code == 8'h11)
      repeat (WAIT_CYCLES) @(negedge clk_in);
  endtask : send
endmodule : dpsc_host_model

// [testbench/tb.sv]
// Self-checking bench for the display power and status command block
`timescale 1ns/1ps
module tb;
  logic clk, arst_n, soft_rst, cmd_valid, read_valid, cmd_hit;
  logic [7:0] cmd, read_data;
  logic rgb, ctl0, hs_p, vs_p, pc_p, de_p, hs_i, vs_i, pc_i, de_i, te_on, te_both;
  logic idle, disp_on, inv_req, xfer, man_osc, rl_ok, fn_ok;
  logic osc_en, bias_en, an_gnd, ca_gnd, scan_en, show_mem, mem_acc, reload, partial, invert, pend;
  logic [31:0] rng = 32'h22;
  logic [7:0] codes [7] = '{8'h0A, 8'h0E, 8'h0F, 8'h13, 8'h20, 8'h55, 8'h00};
  int error_cnt = 0;
  int checks_done = 0;
  dpsc_top dpsc_top_inst (.CLK_IN(clk), .ARST_N_IN(arst_n), .SOFT_RESET_IN(soft_rst), .CMD_VALID_IN(cmd_valid),
    .CMD_IN(cmd), .READ_VALID_OUT(read_valid), .READ_DATA_OUT(read_data), .CMD_HIT_OUT(cmd_hit),
    .RGB_MODE_IN(rgb), .DISPLAY_CONTROL_BIT0_IN(ctl0), .HORIZONTAL_SYNC_PIN_IN(hs_p), .VERTICAL_SYNC_PIN_IN(vs_p),
    .PIXEL_CLOCK_PIN_IN(pc_p), .PIXEL_VALID_PIN_IN(de_p), .INT_HSYNC_IN(hs_i), .INT_VSYNC_IN(vs_i),
    .INT_PCLK_IN(pc_i), .INT_PIXEL_VALID_IN(de_i), .TEAR_ENABLE_IN(te_on), .TEAR_BOTH_BLANKING_IN(te_both),
    .IDLE_MODE_IN(idle), .DISPLAY_ON_IN(disp_on), .INVERSION_ON_REQ_IN(inv_req), .TRANSFER_PHASE_START_IN(xfer),
    .MANUAL_OSC_START_IN(man_osc), .REG_LOAD_OK_IN(rl_ok), .FUNC_OK_IN(fn_ok), .OSC_EN_OUT(osc_en),
    .BIAS_EN_OUT(bias_en), .ANODE_TO_GROUND_OUT(an_gnd), .CATHODE_TO_GROUND_OUT(ca_gnd), .SCAN_EN_OUT(scan_en),
    .SHOW_MEMORY_OUT(show_mem), .FRAME_MEMORY_ACCESS_OUT(mem_acc), .RELOAD_DEFAULTS_OUT(reload),
    .PARTIAL_MODE_OUT(partial), .INVERT_OUT(invert), .INVERT_PENDING_OUT(pend));
  dpsc_host_model host_inst (.clk_in(clk), .hit_in(cmd_hit), .cmd_valid_out(cmd_valid), .cmd_out(cmd));
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  function automatic logic [7:0] sig_exp();
    logic [3:0] s;
    s = (rgb && !ctl0) ? {hs_p, vs_p, pc_p, de_p} : {hs_i, vs_i, pc_i, de_i};
    return {te_on, te_both, s, 2'h0};
  endfunction : sig_exp
  function automatic logic [7:0] pm_exp(input logic awake, input logic part);
    return {1'h0, idle, part, awake, !part, disp_on, 2'h0};
  endfunction : pm_exp
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic shake();
    logic [31:0] r;
    r = xs();
    {rgb, ctl0, hs_p, vs_p, pc_p, de_p, hs_i, vs_i, pc_i, de_i, te_on, te_both, idle, disp_on, rl_ok, fn_ok} = r[15:0];
  endtask : shake
  task automatic rd(input logic [7:0] code, input logic [7:0] exp);
    host_inst.send(code);
    chk({7'h0, read_valid}, 8'h01);
    chk(read_data, exp);
  endtask : rd
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'h1;
    @(negedge clk);
    s = 1'h0;
  endtask : pulse
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial
  begin
    {arst_n, soft_rst, inv_req, xfer, man_osc} = 5'h0;
    shake();
    repeat (6) @(posedge clk);
    @(negedge clk) arst_n = 1'h1;
    repeat (3) @(negedge clk);
    chk({4'h0, an_gnd, osc_en, partial, invert}, 8'h08);
    rd(8'h0A, pm_exp(1'h0, 1'h0));
    rd(8'h0F, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk) shake();
      {soft_rst, inv_req, xfer, man_osc} = rng[19:16];
      if (i < 2)
        {rgb, ctl0} = {1'h1, i[0]};
      rd(8'h0E, sig_exp());
      chk({6'h0, osc_en, mem_acc}, {6'h0, man_osc, man_osc});
    end
    @(negedge clk) {soft_rst, inv_req, xfer, man_osc} = 4'h0;
    host_inst.send(8'h11);
    chk({4'h0, osc_en, bias_en, scan_en, an_gnd}, 8'h0E);
    chk({7'h0, show_mem}, {7'h0, disp_on});
    rd(8'h0F, {rl_ok, fn_ok, 6'h0});
    host_inst.send(8'h11);
    rd(8'h0A, pm_exp(1'h1, 1'h0));
    host_inst.send(8'h12);
    host_inst.send(8'h12);
    chk({7'h0, partial}, 8'h01);
    rd(8'h0A, pm_exp(1'h1, 1'h1));
    host_inst.send(8'h13);
    chk({7'h0, partial}, 8'h00);
    foreach (codes[i])
    begin
      host_inst.send(codes[i]);
      chk({7'h0, host_inst.hit}, {7'h0, codes[i] != 8'h55 && codes[i] != 8'h00});
    end
    pulse(inv_req);
    pulse(xfer);
    chk({6'h0, invert, pend}, 8'h02);
    host_inst.send(8'h20);
    chk({6'h0, invert, pend}, 8'h03);
    pulse(xfer);
    chk({6'h0, invert, pend}, 8'h00);
    host_inst.send(8'h10);
    chk({3'h0, an_gnd, ca_gnd, bias_en, scan_en, mem_acc}, 8'h18);
    man_osc = 1'h1;
    @(negedge clk);
    chk({6'h0, osc_en, mem_acc}, 8'h03);
    rd(8'h0A, pm_exp(1'h0, 1'h0));
    host_inst.send(8'h10);
    chk({7'h0, an_gnd}, 8'h01);
    man_osc = 1'h0;
    host_inst.send(8'h11);
    host_inst.send(8'h12);
    pulse(soft_rst);
    @(negedge clk);
    chk({6'h0, an_gnd, partial}, 8'h02);
    give_verdict();
  end
endmodule : tb
